/* design/eiw_pkg.sv */
// Package of constants and types for the edge interrupt, wake and context block
`default_nettype none
package eiw_pkg;
  // ---------------------------------------------------------------
  // Register offsets (chosen, bank 31 shadow window and control)
  // ---------------------------------------------------------------
  localparam logic [3:0] EIW_OFF_CTRL = 4'h0;
  localparam logic [3:0] EIW_OFF_STAT = 4'h1;
  localparam logic [3:0] EIW_OFF_SH_W = 4'h4;
  localparam logic [3:0] EIW_OFF_SH_STATUS = 4'h5;
  localparam logic [3:0] EIW_OFF_SH_BANK = 4'h6;
  localparam logic [3:0] EIW_OFF_SH_PCH = 4'h7;
  localparam logic [3:0] EIW_OFF_SH_F0L = 4'h8;
  localparam logic [3:0] EIW_OFF_SH_F0H = 4'h9;
  localparam logic [3:0] EIW_OFF_SH_F1L = 4'ha;
  localparam logic [3:0] EIW_OFF_SH_F1H = 4'hb;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EIW_CTRL_GLOBAL_EN = 0;
  localparam int EIW_CTRL_EXT_EN = 1;
  localparam int EIW_CTRL_EDGE = 2;
  localparam int EIW_STAT_PEND = 0;
  localparam int EIW_STAT_SLEEP = 1;
  localparam int EIW_STAT_INSVC = 2;
  localparam int EIW_STATUS_PWRDN = 3;
  localparam int EIW_STATUS_TMOUT = 4;
  localparam logic [7:0] EIW_STATUS_KEEP = 8'he7;
  localparam int EIW_NUM_SH = 8;
  localparam logic [3:0] EIW_SH_BASE = 4'h4;
  localparam logic [7:0] EIW_RST_BYTE = 8'h00;
  localparam logic [2:0] EIW_RST_CTRL = 3'h0;
  localparam logic [14:0] EIW_VECTOR = 15'h0004;

  typedef enum logic [1:0] {
    EIW_RUN = 2'b00,
    EIW_SLEEP = 2'b01,
    EIW_POSTWAKE = 2'b11
  } eiw_state_t;
endpackage : eiw_pkg
`default_nettype wire

/* design/eiw_ctx_if.sv */
// Interface carrying the core context between top and shadow bank
`timescale 1ns/1ps
`default_nettype none
interface eiw_ctx_if;
  logic save;
  logic sw_we;
  logic [2:0] sw_idx;
  logic [7:0] sw_wdata;
  logic [63:0] live;
  logic [63:0] shadow;
  modport top (output save, output sw_we, output sw_idx, output sw_wdata, output live, input shadow);
  modport bank (input save, input sw_we, input sw_idx, input sw_wdata, input live, output shadow);
endinterface : eiw_ctx_if
`default_nettype wire

/* design/eiw_shadow.sv */
// Shadow register bank for automatic context save
`timescale 1ns/1ps
`default_nettype none
module eiw_shadow (
  input wire logic clk_in,
  input wire logic rstn_in,
  eiw_ctx_if.bank ctx
);
  genvar i;
  generate
    for (i = 0; i < eiw_pkg::EIW_NUM_SH; i++)
    begin : g_sh
      logic [7:0] sh_q;
      always_ff @(posedge clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
          sh_q <= eiw_pkg::EIW_RST_BYTE;
        else if (ctx.save)
          sh_q <= ctx.live[i*8 +: 8];
        else if (ctx.sw_we && ctx.sw_idx == 3'(i))
          sh_q <= ctx.sw_wdata;
      end
      assign ctx.shadow[i*8 +: 8] = sh_q;
    end
  endgenerate
endmodule : eiw_shadow
`default_nettype wire

/* design/eiw_top.sv */
// Edge interrupt, wake control and context save/restore
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module eiw_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ext_irq_pin_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic sleep_req_in,
  input wire logic insn_retire_in,
  input wire logic retfie_in,
  input wire logic [14:0] pc_next_in,
  input wire logic [7:0] w_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] bank_select_reg_in,
  input wire logic [7:0] pch_in,
  input wire logic [31:0] indirect_pointer_regs_in,
  output logic wake_out,
  output logic core_run_out,
  output logic vector_out,
  output logic [14:0] vector_addr_out,
  output logic push_out,
  output logic [14:0] push_addr_out,
  output logic restore_out,
  output logic [7:0] w_out,
  output logic [7:0] status_out,
  output logic [7:0] bank_select_reg_out,
  output logic [7:0] pch_out,
  output logic [31:0] indirect_pointer_regs_out
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= ext_irq_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic global_irq_enable_q;
  logic ext_irq_enable_q;
  logic ext_irq_edge_select_q;
  logic ext_irq_pending_q;
  eiw_pkg::eiw_state_t state_q;

  logic edge_seen;
  assign edge_seen = ext_irq_edge_select_q ? (pin_s2_q && !pin_s3_q)
                                           : (!pin_s2_q && pin_s3_q);

  // Clock is stopped in sleep; the pin edge itself latches the wake
  // request, so only this source qualifies as a wake source.
  logic async_wake_q;
  logic arm_n;
  assign arm_n = rst_n && (state_q == eiw_pkg::EIW_SLEEP) && ext_irq_enable_q;
  always_ff @(posedge ext_irq_pin_in or negedge arm_n)
  begin
    if (!arm_n)
      async_wake_q <= 1'b0;
    else
      async_wake_q <= 1'b1;
  end
  // Falling-edge capture for the cleared edge-select case
  logic async_wake_f_q;
  always_ff @(negedge ext_irq_pin_in or negedge arm_n)
  begin
    if (!arm_n)
      async_wake_f_q <= 1'b0;
    else
      async_wake_f_q <= 1'b1;
  end
  logic aw_s1_q;
  logic aw_s2_q;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_s1_q <= 1'b0;
      aw_s2_q <= 1'b0;
    end
    else
    begin
      aw_s1_q <= ext_irq_edge_select_q ? async_wake_q : async_wake_f_q;
      aw_s2_q <= aw_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Control register and pending flag
  // ---------------------------------------------------------------
  logic ctrl_wr;
  logic stat_wr;
  assign ctrl_wr = wr_in && addr_in == eiw_pkg::EIW_OFF_CTRL;
  assign stat_wr = wr_in && addr_in == eiw_pkg::EIW_OFF_STAT;

  logic take_irq;
  logic restore_pend_q;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_irq_enable_q <= 1'b0;
      ext_irq_enable_q <= 1'b0;
      ext_irq_edge_select_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      global_irq_enable_q <= wdata_in[eiw_pkg::EIW_CTRL_GLOBAL_EN];
      ext_irq_enable_q <= wdata_in[eiw_pkg::EIW_CTRL_EXT_EN];
      ext_irq_edge_select_q <= wdata_in[eiw_pkg::EIW_CTRL_EDGE];
    end
    else if (take_irq)
      global_irq_enable_q <= 1'b0;
    else if (retfie_in && restore_pend_q)
      global_irq_enable_q <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ext_irq_pending_q <= 1'b0;
    else if (edge_seen || aw_s2_q)
      ext_irq_pending_q <= 1'b1;
    else if (stat_wr && !wdata_in[eiw_pkg::EIW_STAT_PEND])
      ext_irq_pending_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Sleep, wake and vectoring
  // ---------------------------------------------------------------
  logic irq_req;
  assign irq_req = ext_irq_pending_q && ext_irq_enable_q;
  assign take_irq = irq_req && global_irq_enable_q && insn_retire_in
                    && state_q == eiw_pkg::EIW_RUN;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= eiw_pkg::EIW_RUN;
    else
    begin
      unique case (state_q)
        eiw_pkg::EIW_RUN:
          if (sleep_req_in && !irq_req)
            state_q <= eiw_pkg::EIW_SLEEP;
        eiw_pkg::EIW_SLEEP:
          if (irq_req)
            state_q <= eiw_pkg::EIW_POSTWAKE;
        eiw_pkg::EIW_POSTWAKE:
          if (insn_retire_in)
            state_q <= eiw_pkg::EIW_RUN;
        default:
          state_q <= eiw_pkg::EIW_RUN;
      endcase
    end
  end

  logic wake_now;
  assign wake_now = state_q == eiw_pkg::EIW_SLEEP && irq_req;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_out <= 1'b0;
      core_run_out <= 1'b1;
    end
    else
    begin
      wake_out <= wake_now;
      core_run_out <= state_q != eiw_pkg::EIW_SLEEP || wake_now;
    end
  end

  // ---------------------------------------------------------------
  // Entry and exit of the service routine
  // ---------------------------------------------------------------
  eiw_ctx_if ctx ();
  assign ctx.save = take_irq;
  assign ctx.live = {indirect_pointer_regs_in, pch_in, bank_select_reg_in, status_in, w_in};
  // Shadow window is 4..b only; upper offsets must not alias onto slot 0
  logic sh_sel;
  assign sh_sel = addr_in >= eiw_pkg::EIW_SH_BASE && addr_in <= eiw_pkg::EIW_OFF_SH_F1H;
  assign ctx.sw_we = wr_in && sh_sel;
  assign ctx.sw_idx = 3'(addr_in - eiw_pkg::EIW_SH_BASE);
  assign ctx.sw_wdata = wdata_in;

  eiw_shadow u_shadow (
    .clk_in(clk_in),
    .rstn_in(rst_n),
    .ctx(ctx)
  );

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      restore_pend_q <= 1'b0;
    else if (take_irq)
      restore_pend_q <= 1'b1;
    else if (retfie_in)
      restore_pend_q <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vector_out <= 1'b0;
      vector_addr_out <= eiw_pkg::EIW_VECTOR;
      push_out <= 1'b0;
      push_addr_out <= 15'h0000;
    end
    else
    begin
      vector_out <= take_irq;
      push_out <= take_irq;
      if (take_irq)
        push_addr_out <= pc_next_in;
    end
  end

  logic do_restore;
  assign do_restore = retfie_in && restore_pend_q;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restore_out <= 1'b0;
      w_out <= eiw_pkg::EIW_RST_BYTE;
      status_out <= eiw_pkg::EIW_RST_BYTE;
      bank_select_reg_out <= eiw_pkg::EIW_RST_BYTE;
      pch_out <= eiw_pkg::EIW_RST_BYTE;
      indirect_pointer_regs_out <= 32'h00000000;
    end
    else
    begin
      restore_out <= do_restore;
      if (do_restore)
      begin
        w_out <= ctx.shadow[7:0];
        // Timeout and powerdown keep live values
        status_out <= (ctx.shadow[15:8] & eiw_pkg::EIW_STATUS_KEEP)
                      | (status_in & ~eiw_pkg::EIW_STATUS_KEEP);
        bank_select_reg_out <= ctx.shadow[23:16];
        pch_out <= ctx.shadow[31:24];
        indirect_pointer_regs_out <= ctx.shadow[63:32];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      rdata_out <= eiw_pkg::EIW_RST_BYTE;
    else if (rd_in)
    begin
      if (addr_in == eiw_pkg::EIW_OFF_CTRL)
        rdata_out <= {5'h00, ext_irq_edge_select_q, ext_irq_enable_q, global_irq_enable_q};
      else if (addr_in == eiw_pkg::EIW_OFF_STAT)
        rdata_out <= {5'h00, restore_pend_q, state_q == eiw_pkg::EIW_SLEEP, ext_irq_pending_q};
      else if (sh_sel)
        rdata_out <= ctx.shadow[{ctx.sw_idx, 3'b000} +: 8];
      else
        rdata_out <= eiw_pkg::EIW_RST_BYTE;
    end
    else
      rdata_out <= eiw_pkg::EIW_RST_BYTE;
  end
endmodule : eiw_top
`default_nettype wire

/* tb/eiw_core_model.sv */
// Behavioural core: one instruction retired per cycle while awake
`timescale 1ns/1ps
`default_nettype none
module eiw_core_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic run_in,
  input wire logic vec_in,
  input wire logic [14:0] vec_addr_in,
  output logic retire_out,
  output logic [14:0] pc_out
);
  initial
  begin
    retire_out = 1'b0;
    pc_out = 15'h0100;
  end
  // Clock stopped in sleep, so nothing retires there
  always @(posedge clk_in)
  begin
    retire_out <= go_in && run_in;
    if (vec_in)
      pc_out <= vec_addr_in;
    else if (retire_out)
      pc_out <= pc_out + 15'h0001;
  end
endmodule : eiw_core_model
`default_nettype wire

/* tb/eiw_top_monitor.sv */
// Checker on the top ports of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module eiw_top_monitor (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic rd_in,
  input wire logic insn_retire_in,
  input wire logic [14:0] pc_next_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] rdata_out,
  input wire logic wake_out,
  input wire logic core_run_out,
  input wire logic vector_out,
  input wire logic [14:0] vector_addr_out,
  input wire logic push_out,
  input wire logic [14:0] push_addr_out,
  input wire logic restore_out,
  input wire logic [7:0] status_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  a_vec_addr: assert property (vector_out |-> vector_addr_out == 15'h0004) else $error("vector addr");
  a_push_vec: assert property (vector_out |-> push_out) else $error("no push");
  a_push_addr: assert property (push_out |-> push_addr_out == $past(pc_next_in)) else $error("push addr");
  a_vec_cause: assert property (vector_out |-> $past(insn_retire_in)) else $error("vector cause");
  a_wake_no_vec: assert property (wake_out |-> !vector_out) else $error("vector at wake");
  a_sleep_quiet: assert property (!core_run_out |-> !vector_out && !push_out) else $error("vector asleep");
  a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("rdata idle");
  a_status_keep: assert property (restore_out |-> status_out[4:3] == $past(status_in[4:3])) else $error("flags");
endmodule : eiw_top_monitor
bind eiw_top eiw_top_monitor i_eiw_top_monitor (.clk_in, .rstn_in, .rd_in, .insn_retire_in, .pc_next_in, .status_in,
  .rdata_out, .wake_out, .core_run_out, .vector_out, .vector_addr_out, .push_out, .push_addr_out, .restore_out,
  .status_out);
`default_nettype wire

/* tb/eiw_top_tb.sv */
// Self-checking bench of the interrupt, wake and context block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, a, b); end end
module eiw_top_tb;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} eiw_row_t;
  logic clk_in, rstn_in, pin, wr, rd, slp, ret, go, retire, wake, run, vec, push, rest;
  logic [3:0] addr;
  logic [7:0] wdat, rdat, w, st, bank_sel, pch, w_o, st_o, bank_sel_o, pch_o;
  logic [31:0] ptr_regs, ptr_regs_o;
  logic [14:0] pc, vaddr, paddr;
  int err_count, cmp_count, cyc;
  eiw_row_t rows [10] = '{'{4'h0, 8'hff, 8'h07}, '{4'h0, 8'h00, 8'h00}, '{4'h1, 8'hff, 8'h00},
    '{4'h4, 8'ha5, 8'ha5}, '{4'h6, 8'h5a, 8'h5a}, '{4'h7, 8'h3c, 8'h3c}, '{4'h8, 8'hc3, 8'hc3},
    '{4'hb, 8'h96, 8'h96}, '{4'hc, 8'hff, 8'h00}, '{4'hf, 8'hff, 8'h00}};
  eiw_top i_eiw_top (.clk_in, .rstn_in, .ext_irq_pin_in(pin), .addr_in(addr), .wdata_in(wdat), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdat), .sleep_req_in(slp), .insn_retire_in(retire), .retfie_in(ret), .pc_next_in(pc),
    .w_in(w), .status_in(st), .bank_select_reg_in(bank_sel), .pch_in(pch), .indirect_pointer_regs_in(ptr_regs),
    .wake_out(wake), .core_run_out(run),
    .vector_out(vec), .vector_addr_out(vaddr), .push_out(push), .push_addr_out(paddr), .restore_out(rest),
    .w_out(w_o), .status_out(st_o), .bank_select_reg_out(bank_sel_o), .pch_out(pch_o),
    .indirect_pointer_regs_out(ptr_regs_o));
  eiw_core_model i_eiw_core_model (.clk_in, .go_in(go), .run_in(run), .vec_in(vec), .vec_addr_in(vaddr),
    .retire_out(retire), .pc_out(pc));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Run is about 220 cycles; anything far past that is a hang
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      test_done;
    end
  end
  task automatic tend(input string n);
    $display("test %s ended, mismatches %0d", n, err_count);
  endtask : tend
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    `CHK(rdat, e)
  endtask : rd_chk
  task automatic pulse(input bit s);
    @(posedge clk_in);
    if (s)
      slp <= 1'b1;
    else
      ret <= 1'b1;
    @(posedge clk_in);
    slp <= 1'b0;
    ret <= 1'b0;
  endtask : pulse
  // Pin change, then time for the synchroniser to settle
  task automatic setpin(input logic l);
    @(posedge clk_in);
    pin <= l;
    repeat (8) @(posedge clk_in);
  endtask : setpin
  // Output picked by index: 0 vector, 1 wake, 2 restore
  function automatic logic pick(input int k);
    return (k == 0) ? vec : (k == 1) ? wake : rest;
  endfunction : pick
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    #1;
    while (pick(k) !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK(pick(k), 1'b1)
  endtask : wait_hi
  initial
  begin
    {pin, wr, rd, slp, ret, go, addr, wdat} = '0;
    {w, st, bank_sel, pch, ptr_regs} = 64'h11ff2233_44556677;
    rstn_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    go <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    `CHK(run, 1'b1)
    `CHK(vaddr, 15'h0004)
    tend("reset");
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    tend("registers");
    for (int s = 0; s < 2; s++)
    begin
      wr_reg(4'h0, s[0] ? 8'h06 : 8'h02);
      setpin(s[0]);
      wr_reg(4'h1, 8'h00);
      setpin(!s[0]);
      rd_chk(4'h1, 8'h00);
      setpin(s[0]);
      rd_chk(4'h1, 8'h01);
    end
    tend("edges");
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h07);
    setpin(1'b0);
    @(posedge clk_in);
    pin <= 1'b1;
    wait_hi(0);
    `CHK(push, 1'b1)
    foreach (rows[i])
      if (rows[i].a inside {4'h4, 4'h6, 4'h7, 4'h8, 4'hb})
        rd_chk(rows[i].a, (i == 7) ? 8'h44 : (i == 6) ? 8'h77 : w + 8'(i - 3) * 8'h11);
    wr_reg(4'h1, 8'h00);
    rd_chk(4'h1, 8'h04);
    @(posedge clk_in);
    {w, st, bank_sel} <= 24'h990088;
    wr_reg(4'h4, 8'h5a);
    pulse(1'b0);
    wait_hi(2);
    `CHK(w_o, 8'h5a)
    `CHK(bank_sel_o, 8'h22)
    `CHK(pch_o, 8'h33)
    `CHK(ptr_regs_o, 32'h44556677)
    `CHK(st_o, 8'hff & eiw_pkg::EIW_STATUS_KEEP)
    rd_chk(4'h0, 8'h07);
    tend("context");
    wr_reg(4'h0, 8'h05);
    pulse(1'b1);
    rd_chk(4'h1, 8'h02);
    setpin(1'b0);
    setpin(1'b1);
    `CHK(run, 1'b0)
    rd_chk(4'h1, 8'h03);
    wr_reg(4'h0, 8'h06);
    wait_hi(1);
    rd_chk(4'h1, 8'h01);
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h07);
    setpin(1'b0);
    pulse(1'b1);
    @(posedge clk_in);
    pin <= 1'b1;
    wait_hi(1);
    wait_hi(0);
    wr_reg(4'h1, 8'h00);
    pulse(1'b0);
    wait_hi(2);
    tend("wake");
    test_done;
  end
endmodule : eiw_top_tb
`default_nettype wire
